// ===== wmba_pkg.sv
// Overview of operation
// - One instruction cycle is one core clock
// - Internal RAM or no access uses short count
// - Operand outside internal RAM uses longer count
// - Counts assume program fetched from internal ROM
// - External byte reads add read waits, except short direct forms
// - Word load/store direct: 3 bytes, 10 cycles
// - Word accumulator moves only with other pairs
// - Add writes sum, carry, all flags
// - Add-with-carry to short direct byte writes back
// - Subtract from short direct byte returns borrow
// - Subtract-with-borrow subtracts operand and carry
// - AND updates zero flag only
// - Accumulator-immediate forms: 2 bytes, 4 cycles
// - Register-destination forms write back the register
// - Unaffected flags keep their previous value
// - Short direct window FE20-FF1F, word even only
// - Special-register forms cannot reach FFD0-FFDF
package wmba_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int CLKS_PER_INSTR_CYCLE = (CLK_PERIOD_NS * CLK_FREQ_MHZ) / 1000;
  localparam logic [15:0] SADDR_LO = 16'hfe20;
  localparam logic [15:0] SADDR_HI = 16'hff1f;
  localparam logic [15:0] SFR_HOLE_LO = 16'hffd0;
  localparam logic [15:0] SFR_HOLE_HI = 16'hffdf;
  localparam logic [1:0] PAIR_ACC = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] NIB_MAX = 4'hf;
  localparam logic [5:0] CYC_REG = 6'h04;
  localparam logic [5:0] CYC_SADDR_IMM_INT = 6'h06;
  localparam logic [5:0] CYC_SADDR_IMM_EXT = 6'h08;
  localparam logic [5:0] CYC_SADDR_INT = 6'h04;
  localparam logic [5:0] CYC_SADDR_EXT = 6'h05;
  localparam logic [5:0] CYC_FAR_INT = 6'h08;
  localparam logic [5:0] CYC_FAR_EXT = 6'h09;
  localparam logic [5:0] CYC_HL_INT = 6'h04;
  localparam logic [5:0] CYC_HL_EXT = 6'h05;
  localparam logic [5:0] CYC_W16_INT = 6'h0a;
  localparam logic [5:0] CYC_W16_EXT = 6'h0c;
  localparam logic [5:0] CYC_ONE = 6'h01;
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;

  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_ADD_WITH_CARRY = 3'b001,
    OP_SUB = 3'b010,
    OP_SUBTRACT_WITH_BORROW = 3'b011,
    OP_AND = 3'b100,
    OP_WORD_MOVE = 3'b101,
    OP_WORD_EXCHANGE = 3'b110
  } wmba_op_t;

  typedef enum logic [3:0] {
    FM_ACC_IMM = 4'b0000,
    FM_REG_ACC = 4'b0001,
    FM_ACC_REG = 4'b0010,
    FM_SADDR_IMM = 4'b0011,
    FM_ACC_SADDR = 4'b0100,
    FM_ACC_ADDR16 = 4'b0101,
    FM_ACC_PTR = 4'b0110,
    FM_ACC_PTR_DISP = 4'b0111,
    FM_ACC_PTR_IDX = 4'b1000,
    FM_WACC_FROM_PAIR = 4'b1001,
    FM_PAIR_FROM_WACC = 4'b1010,
    FM_WLOAD_ADDR16 = 4'b1011,
    FM_WSTORE_ADDR16 = 4'b1100,
    FM_WACC_SADDRP = 4'b1101
  } wmba_form_t;

  typedef struct packed {
    wmba_op_t op;
    wmba_form_t form;
    logic [7:0] dst;
    logic [7:0] src;
    logic [15:0] word_accumulator;
    logic [15:0] word_operand;
    logic [1:0] register_pair_operand;
    logic [15:0] addr;
    logic ext;
    logic sfr_sel;
    logic [3:0] wait_rd;
    logic [3:0] wait_wr;
  } wmba_req_t;

  typedef struct packed {
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } wmba_flags_t;

  typedef struct packed {
    logic [7:0] byte_res;
    logic [15:0] word_accumulator;
    logic [15:0] word_operand;
    wmba_flags_t flags;
    logic [2:0] len;
    logic [5:0] cycles;
  } wmba_res_t;
endpackage

// ===== wmba_exec.sv
`timescale 1ns/100ps
module wmba_exec import wmba_pkg::*; (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // Request
  input wire logic REQ_VALID_I,
  input wire wmba_req_t REQ_I,
  output logic REQ_READY_O,
  // Result
  output logic DONE_O,
  output logic ERR_O,
  output wmba_res_t RES_O
);
  typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} wmba_state_t;

  logic rst_meta_reg;
  logic rst_b_reg;
  wmba_state_t state_reg;
  logic [5:0] cnt_reg;
  logic done_reg;
  logic err_reg;
  wmba_res_t res_reg;
  wmba_flags_t flags_reg;
  logic accept;
  logic illegal;
  logic [5:0] cyc;
  logic [2:0] len;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] alu_byte;
  wmba_flags_t flags_next;
  logic [5:0] n6;
  logic [5:0] m6;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_b_reg <= rst_meta_reg;
    end
  end

  assign REQ_READY_O = (state_reg == ST_IDLE);
  assign accept = REQ_VALID_I && REQ_READY_O;
  assign n6 = {2'b00, REQ_I.wait_rd};
  assign m6 = {2'b00, REQ_I.wait_wr};

  // Cycle and length table; figures hold for internal ROM fetch
  always_comb begin
    cyc = CYC_REG;
    len = LEN_2;
    case (REQ_I.form)
      FM_ACC_IMM, FM_REG_ACC, FM_ACC_REG: begin
        cyc = CYC_REG;
        len = LEN_2;
      end
      FM_SADDR_IMM: begin
        cyc = REQ_I.ext ? CYC_SADDR_IMM_EXT : CYC_SADDR_IMM_INT;
        len = LEN_3;
      end
      FM_ACC_SADDR: begin
        cyc = REQ_I.ext ? CYC_SADDR_EXT : CYC_SADDR_INT;
        len = LEN_2;
      end
      FM_ACC_ADDR16: begin
        cyc = REQ_I.ext ? 6'(CYC_FAR_EXT + n6) : CYC_FAR_INT;
        len = LEN_3;
      end
      FM_ACC_PTR: begin
        cyc = REQ_I.ext ? 6'(CYC_HL_EXT + n6) : CYC_HL_INT;
        len = LEN_1;
      end
      FM_ACC_PTR_DISP, FM_ACC_PTR_IDX: begin
        cyc = REQ_I.ext ? 6'(CYC_FAR_EXT + n6) : CYC_FAR_INT;
        len = LEN_2;
      end
      FM_WACC_FROM_PAIR, FM_PAIR_FROM_WACC: begin
        cyc = CYC_REG;
        len = LEN_1;
      end
      FM_WLOAD_ADDR16: begin
        cyc = REQ_I.ext ? 6'(CYC_W16_EXT + (n6 << 1)) : CYC_W16_INT;
        len = LEN_3;
      end
      FM_WSTORE_ADDR16: begin
        cyc = REQ_I.ext ? 6'(CYC_W16_EXT + (m6 << 1)) : CYC_W16_INT;
        len = LEN_3;
      end
      FM_WACC_SADDRP: begin
        cyc = REQ_I.ext ? CYC_SADDR_IMM_EXT : CYC_SADDR_IMM_INT;
        len = LEN_2;
      end
      default: begin
        cyc = CYC_REG;
        len = LEN_2;
      end
    endcase
  end

  // Illegal operand combinations finish at once and change nothing
  always_comb begin
    illegal = 1'b0;
    if ((REQ_I.form == FM_SADDR_IMM || REQ_I.form == FM_ACC_SADDR || REQ_I.form == FM_WACC_SADDRP) &&
        (REQ_I.addr < SADDR_LO || REQ_I.addr > SADDR_HI)) begin
      illegal = 1'b1;
    end
    if (REQ_I.form == FM_WACC_SADDRP && REQ_I.addr[0]) begin
      illegal = 1'b1;
    end
    if (REQ_I.sfr_sel && REQ_I.addr >= SFR_HOLE_LO && REQ_I.addr <= SFR_HOLE_HI) begin
      illegal = 1'b1;
    end
    if ((REQ_I.op == OP_WORD_MOVE || REQ_I.op == OP_WORD_EXCHANGE) &&
        (REQ_I.form == FM_WACC_FROM_PAIR || REQ_I.form == FM_PAIR_FROM_WACC) &&
        REQ_I.register_pair_operand == PAIR_ACC) begin
      illegal = 1'b1;
    end
    if (REQ_I.op == OP_WORD_EXCHANGE && REQ_I.form != FM_WACC_FROM_PAIR) begin
      illegal = 1'b1;
    end
    if ((REQ_I.op == OP_WORD_MOVE) != (REQ_I.form >= FM_WACC_FROM_PAIR) && REQ_I.op != OP_WORD_EXCHANGE) begin
      illegal = 1'b1;
    end
    if (REQ_I.form > FM_WACC_SADDRP) begin
      illegal = 1'b1;
    end
  end

  // Byte arithmetic; subtract has its own subtractor, and its borrow lands in the carry bit
  always_comb begin
    sum9 = 9'h000;
    nib5 = 5'h00;
    alu_byte = BYTE_ZERO;
    flags_next = flags_reg;
    case (REQ_I.op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        sum9 = 9'({1'b0, REQ_I.dst} + {1'b0, REQ_I.src} + 9'(REQ_I.op == OP_ADD_WITH_CARRY && flags_reg.carry_flag));
        nib5 = 5'({1'b0, REQ_I.dst[3:0]} + {1'b0, REQ_I.src[3:0]} +
                  5'(REQ_I.op == OP_ADD_WITH_CARRY && flags_reg.carry_flag));
        alu_byte = sum9[7:0];
        flags_next.carry_flag = sum9[8];
        flags_next.aux_carry_flag = nib5[4];
        flags_next.zero_flag = (alu_byte == BYTE_ZERO);
      end
      OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
        sum9 = 9'({1'b0, REQ_I.dst} - {1'b0, REQ_I.src} -
                  9'(REQ_I.op == OP_SUBTRACT_WITH_BORROW && flags_reg.carry_flag));
        nib5 = 5'({1'b0, REQ_I.dst[3:0]} - {1'b0, REQ_I.src[3:0]} -
                  5'(REQ_I.op == OP_SUBTRACT_WITH_BORROW && flags_reg.carry_flag));
        alu_byte = sum9[7:0];
        flags_next.carry_flag = sum9[8];
        flags_next.aux_carry_flag = nib5[4];
        flags_next.zero_flag = (alu_byte == BYTE_ZERO);
      end
      OP_AND: begin
        alu_byte = REQ_I.dst & REQ_I.src;
        flags_next.zero_flag = (alu_byte == BYTE_ZERO);
      end
      default: begin
        alu_byte = REQ_I.dst;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (accept && illegal) begin
            done_reg <= 1'b1;
            err_reg <= 1'b1;
          end else if (accept) begin
            state_reg <= ST_EXEC;
            cnt_reg <= 6'(cyc - CYC_ONE);
            err_reg <= 1'b0;
          end
        end
        ST_EXEC: begin
          cnt_reg <= 6'(cnt_reg - CYC_ONE);
          if (cnt_reg == CYC_ONE) begin
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Flags and results commit on acceptance so a following carry chain sees them
  always_ff @(posedge CORE_CLK_I or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      flags_reg <= '0;
      res_reg <= '0;
    end else if (accept && !illegal) begin
      flags_reg <= flags_next;
      res_reg.flags <= flags_next;
      res_reg.byte_res <= alu_byte;
      res_reg.len <= len;
      res_reg.cycles <= cyc;
      res_reg.word_accumulator <= REQ_I.word_accumulator;
      res_reg.word_operand <= REQ_I.word_operand;
      if (REQ_I.form == FM_WACC_FROM_PAIR || REQ_I.form == FM_WLOAD_ADDR16 || REQ_I.form == FM_WACC_SADDRP) begin
        res_reg.word_accumulator <= REQ_I.word_operand;
      end
      if (REQ_I.op == OP_WORD_EXCHANGE || REQ_I.form == FM_PAIR_FROM_WACC || REQ_I.form == FM_WSTORE_ADDR16) begin
        res_reg.word_operand <= REQ_I.word_accumulator;
      end
    end
  end

  assign DONE_O = done_reg;
  assign ERR_O = err_reg;
  assign RES_O = res_reg;

  // Checking helpers
  logic [5:0] elapsed_reg;
  always_ff @(posedge CORE_CLK_I or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      elapsed_reg <= 6'h00;
    end else if (accept) begin
      elapsed_reg <= CYC_ONE;
    end else if (state_reg == ST_EXEC) begin
      elapsed_reg <= 6'(elapsed_reg + CYC_ONE);
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!rst_b_reg);

  sequence s_good_accept;
    accept && !illegal;
  endsequence

  property p_cycle_count;
    DONE_O && !ERR_O |-> elapsed_reg == RES_O.cycles;
  endproperty
  a_cycle_count: assert property (p_cycle_count) else $error("Done not at cycle count");

  property p_saddr_int;
    s_good_accept ##0 (REQ_I.form == FM_ACC_SADDR && !REQ_I.ext) |=> RES_O.cycles == 6'h04 && RES_O.len == 3'h2;
  endproperty
  a_saddr_int: assert property (p_saddr_int) else $error("Short direct internal count wrong");

  property p_saddr_ext;
    s_good_accept ##0 (REQ_I.form == FM_SADDR_IMM && REQ_I.ext) |=> RES_O.cycles == 6'h08 && RES_O.len == 3'h3;
  endproperty
  a_saddr_ext: assert property (p_saddr_ext) else $error("Short direct external count wrong");

  property p_far_waits;
    s_good_accept ##0 (REQ_I.form == FM_ACC_ADDR16 && REQ_I.ext) |=>
      RES_O.cycles == 6'(6'h09 + {2'b00, $past(REQ_I.wait_rd)});
  endproperty
  a_far_waits: assert property (p_far_waits) else $error("Read waits not added");

  property p_wload;
    s_good_accept ##0 (REQ_I.form == FM_WLOAD_ADDR16 && REQ_I.ext) |=>
      RES_O.cycles == 6'(6'h0c + {1'b0, $past(REQ_I.wait_rd), 1'b0}) && $stable(flags_reg)
      && RES_O.word_accumulator == $past(REQ_I.word_operand);
  endproperty
  a_wload: assert property (p_wload) else $error("Word load count or flags wrong");

  property p_pair_acc_refused;
    accept && REQ_I.op == OP_WORD_MOVE && REQ_I.form == FM_WACC_FROM_PAIR &&
      REQ_I.register_pair_operand == PAIR_ACC |=> DONE_O && ERR_O;
  endproperty
  a_pair_acc_refused: assert property (p_pair_acc_refused) else $error("Accumulator pair not refused");

  property p_add;
    s_good_accept ##0 (REQ_I.op == OP_ADD) |=>
      {flags_reg.carry_flag, RES_O.byte_res} == 9'({1'b0, $past(REQ_I.dst)} + {1'b0, $past(REQ_I.src)});
  endproperty
  a_add: assert property (p_add) else $error("Add result or carry wrong");

  property p_and_flags;
    s_good_accept ##0 (REQ_I.op == OP_AND) |=>
      $stable(flags_reg.carry_flag) && $stable(flags_reg.aux_carry_flag);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("AND changed carry flags");

  property p_window;
    accept && REQ_I.form == FM_ACC_SADDR && REQ_I.addr > SADDR_HI |=> DONE_O && ERR_O && REQ_READY_O;
  endproperty
  a_window: assert property (p_window) else $error("Out of window not refused");

  property p_zero;
    s_good_accept ##0 (REQ_I.op != OP_WORD_MOVE && REQ_I.op != OP_WORD_EXCHANGE) |=>
      flags_reg.zero_flag == (RES_O.byte_res == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("Zero flag disagrees with result");
endmodule

// ===== wmba_mem.sv
`timescale 1ns/100ps
module wmba_mem import wmba_pkg::*; ();
  logic [7:0] mem_reg [65536];
  // Unwritten bytes hold a pattern so stale zeros cannot pass
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_reg[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
    end
  end
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem_reg[a];
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    mem_reg[a] = d;
  endtask
  function automatic logic saddr_ok(input logic [15:0] a);
    return a >= SADDR_LO && a <= SADDR_HI;
  endfunction
endmodule

// ===== testbench.sv
`timescale 1ns/100ps
module testbench import wmba_pkg::*; ();
  logic CORE_CLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic REQ_VALID_I = 1'b0;
  wmba_req_t REQ_I = '0;
  logic REQ_READY_O;
  logic DONE_O;
  logic ERR_O;
  wmba_res_t RES_O;
  int bad_count = 0;
  int total_checks = 0;
  // Model flags: zero, aux carry, carry
  logic [2:0] fl = 3'h0;
  wmba_form_t bf [9] = '{FM_ACC_IMM, FM_REG_ACC, FM_ACC_REG, FM_SADDR_IMM, FM_ACC_SADDR,
    FM_ACC_ADDR16, FM_ACC_PTR, FM_ACC_PTR_DISP, FM_ACC_PTR_IDX};
  wmba_form_t wf [5] = '{FM_WACC_FROM_PAIR, FM_PAIR_FROM_WACC, FM_WLOAD_ADDR16, FM_WSTORE_ADDR16,
    FM_WACC_SADDRP};
  logic [15:0] sa [4] = '{16'hfe1f, 16'hfe20, 16'hff1f, 16'hff20};

  always #10 CORE_CLK_I = ~CORE_CLK_I;

  wmba_exec dut (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I),
    .REQ_READY_O(REQ_READY_O), .DONE_O(DONE_O), .ERR_O(ERR_O), .RES_O(RES_O));
  wmba_mem mem ();

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flg(input wmba_flags_t got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flags got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic int cyc(wmba_req_t r);
    case (r.form)
      FM_SADDR_IMM, FM_WACC_SADDRP: return r.ext ? 8 : 6;
      FM_ACC_SADDR: return r.ext ? 5 : 4;
      FM_ACC_PTR: return r.ext ? 5 + r.wait_rd : 4;
      FM_ACC_ADDR16, FM_ACC_PTR_DISP, FM_ACC_PTR_IDX: return r.ext ? 9 + r.wait_rd : 8;
      FM_WLOAD_ADDR16: return r.ext ? 12 + 2 * r.wait_rd : 10;
      FM_WSTORE_ADDR16: return r.ext ? 12 + 2 * r.wait_wr : 10;
      default: return 4;
    endcase
  endfunction

  function automatic int elen(wmba_form_t f);
    if (f inside {FM_ACC_PTR, FM_WACC_FROM_PAIR, FM_PAIR_FROM_WACC}) return 1;
    return (f inside {FM_SADDR_IMM, FM_ACC_ADDR16, FM_WLOAD_ADDR16, FM_WSTORE_ADDR16}) ? 3 : 2;
  endfunction

  // Valid stays up until the next request, so back-to-back issue needs no gap
  task automatic run(input wmba_req_t r, input logic bad);
    int j;
    int a;
    int b;
    int c;
    int s;
    int h;
    logic [2:0] nf;
    logic [15:0] wa;
    logic [15:0] wo;
    REQ_I = r;
    REQ_VALID_I = 1'b1;
    j = 0;
    while (REQ_READY_O !== 1'b1 && j < 50) begin
      @(posedge CORE_CLK_I);
      #1;
      j++;
    end
    @(posedge CORE_CLK_I);
    #1;
    if (!bad) chk_val(16'(REQ_READY_O), 16'h0);
    j = 0;
    while (DONE_O !== 1'b1 && j < 40) begin
      @(posedge CORE_CLK_I);
      #1;
      j++;
    end
    a = r.dst;
    b = r.src;
    c = (r.op inside {OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW}) ? int'(fl[0]) : 0;
    s = 0;
    nf = fl;
    wa = r.word_accumulator;
    wo = r.word_operand;
    case (r.op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        s = a + b + c;
        h = a % 16 + b % 16 + c;
        nf[1:0] = {h > 15, s > 255};
      end
      OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
        s = a - b - c;
        h = a % 16 - b % 16 - c;
        nf[1:0] = {h < 0, s < 0};
      end
      OP_AND: s = a & b;
      OP_WORD_EXCHANGE: begin
        wa = r.word_operand;
        wo = r.word_accumulator;
      end
      default: if (r.form inside {FM_WACC_FROM_PAIR, FM_WLOAD_ADDR16, FM_WACC_SADDRP}) wa = wo; else wo = wa;
    endcase
    if (r.op inside {[OP_ADD:OP_AND]}) nf[2] = s[7:0] == 8'h00;
    chk_val(16'(ERR_O), 16'(bad));
    chk_flg(RES_O.flags, bad ? fl : nf);
    if (bad) begin
      chk_val(16'(j), 16'h0);
    end else begin
      fl = nf;
      chk_val(16'(j + 1), 16'(cyc(r)));
      chk_val(16'(RES_O.cycles), 16'(cyc(r)));
      chk_val(16'(RES_O.len), 16'(elen(r.form)));
      if (r.op inside {OP_WORD_MOVE, OP_WORD_EXCHANGE}) begin
        chk_val(RES_O.word_accumulator, wa);
        chk_val(RES_O.word_operand, wo);
      end else begin
        chk_val(16'(RES_O.byte_res), 16'(s[7:0]));
      end
      if (r.form == FM_SADDR_IMM) mem.wr(r.addr, s[7:0]);
    end
  endtask

  task automatic rnd(input int k);
    wmba_req_t r;
    r = '0;
    r.dst = 8'($urandom);
    r.src = 8'($urandom);
    r.word_accumulator = 16'($urandom);
    r.word_operand = 16'($urandom);
    r.register_pair_operand = 2'($urandom_range(3, 1));
    r.addr = 16'($urandom);
    r.wait_rd = 4'($urandom_range(7, 0));
    r.wait_wr = 4'($urandom_range(7, 0));
    if (k % 4 == 0) begin
      r.op = ($urandom_range(1, 0) == 1) ? OP_WORD_EXCHANGE : OP_WORD_MOVE;
      r.form = (r.op == OP_WORD_EXCHANGE) ? FM_WACC_FROM_PAIR : wf[$urandom_range(4, 0)];
    end else begin
      r.op = wmba_op_t'($urandom_range(4, 0));
      r.form = bf[$urandom_range(8, 0)];
    end
    if (r.form inside {FM_SADDR_IMM, FM_ACC_SADDR}) r.addr = SADDR_LO + 16'($urandom_range(255, 0));
    if (r.form == FM_WACC_SADDRP) r.addr = SADDR_LO + 16'(2 * $urandom_range(127, 0));
    if (r.form inside {[FM_ACC_SADDR:FM_ACC_PTR_IDX]}) r.src = mem.rd(r.addr);
    if (r.form == FM_SADDR_IMM) r.dst = mem.rd(r.addr);
    r.ext = (r.form inside {[FM_SADDR_IMM:FM_ACC_PTR_IDX], FM_WLOAD_ADDR16, FM_WSTORE_ADDR16, FM_WACC_SADDRP})
      && ($urandom_range(1, 0) == 1);
    run(r, 1'b0);
  endtask

  task automatic ill(input wmba_op_t op, input wmba_form_t f, input logic [1:0] p, input logic [15:0] a);
    wmba_req_t r;
    r = '0;
    r.op = op;
    r.form = f;
    r.register_pair_operand = p;
    r.addr = a;
    r.sfr_sel = a[15:4] == 12'hffd;
    run(r, 1'b1);
  endtask

  initial begin
    void'($urandom(32'h5578a11a));
    repeat (2) @(posedge CORE_CLK_I);
    #1;
    RST_B_I = 1'b1;
    repeat (3) @(posedge CORE_CLK_I);
    #1;
    for (int k = 0; k < 150; k++) rnd(k);
    foreach (sa[i]) begin
      run('{op: OP_ADD_WITH_CARRY, form: FM_SADDR_IMM, dst: mem.rd(sa[i]), src: 8'hf1, addr: sa[i],
        default: '0}, !mem.saddr_ok(sa[i]));
    end
    ill(OP_ADD, FM_ACC_ADDR16, 2'h1, 16'hffd0);
    ill(OP_SUB, FM_ACC_ADDR16, 2'h1, 16'hffdf);
    ill(OP_WORD_MOVE, FM_WACC_FROM_PAIR, 2'h0, 16'h0000);
    ill(OP_WORD_EXCHANGE, FM_PAIR_FROM_WACC, 2'h1, 16'h0000);
    ill(OP_AND, FM_WLOAD_ADDR16, 2'h1, 16'h0000);
    ill(OP_ADD, FM_ACC_SADDR, 2'h1, 16'hff20);
    ill(OP_WORD_MOVE, FM_WACC_SADDRP, 2'h1, 16'hfe21);
    for (int k = 0; k < 150; k++) rnd(k);
    REQ_VALID_I = 1'b0;
    @(posedge CORE_CLK_I);
    conclude;
  end

  initial begin
    #400000;
    bad_count++;
    conclude;
  end
endmodule
